/* inc/ifd_pkg.sv */
// ifd_pkg: instruction word layout, operand field positions and opcode patterns
// assumes a 14-bit instruction word with bit 13 as the most significant bit
package ifd_pkg;

    localparam int WORD_W = 14;
    localparam int REG_LOC_W = 7;
    localparam int BIT_IDX_W = 3;
    localparam int DATA_W = 8;
    localparam int PTR_COUNT = 2;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // operand field positions
    localparam int REG_LOC_LSB = 0;
    localparam int DEST_BIT = 7;
    localparam int BIT_IDX_LSB = 7;
    localparam int LIT8_LSB = 0;
    localparam int LIT11_LSB = 0;
    localparam int LIT7_LSB = 0;
    localparam int LIT5_LSB = 0;
    localparam int LIT9_LSB = 0;
    localparam int LIT6_LSB = 0;
    localparam int PTR_LIT_SEL_BIT = 6;
    localparam int PTR_STEP_SEL_BIT = 2;
    localparam int STEP_LSB = 0;
    localparam int BIT_TEST_BIT = 11;
    localparam int GROUP_LSB = 12;
    localparam int SUB_LSB = 8;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // opcode patterns
    localparam logic [1:0] GROUP_LOW = 2'h0;
    localparam logic [1:0] GROUP_BIT = 2'h1;
    localparam logic [1:0] GROUP_JUMP = 2'h2;
    localparam logic [1:0] GROUP_HIGH = 2'h3;
    localparam logic [3:0] SUB_NONE = 4'h0;
    localparam logic [15:0] HIGH_BYTE_SET = 16'h28E0;
    localparam logic [15:0] HIGH_LIT8_SET = 16'h5711;
    localparam logic [4:0] OFFSET_JUMP_OP = 5'h19;
    localparam logic [6:0] PAGE_LOAD_OP = 7'h63;
    localparam logic [6:0] PTR_ADD_OP = 7'h62;
    localparam logic [6:0] PTR_READ_LIT_OP = 7'h7E;
    localparam logic [6:0] PTR_WRITE_LIT_OP = 7'h7F;
    localparam logic [8:0] BANK_LOAD_OP = 9'h001;
    localparam logic [10:0] PTR_READ_STEP_OP = 11'h002;
    localparam logic [10:0] PTR_WRITE_STEP_OP = 11'h003;
    localparam logic [13:0] OP_IDLE = 14'h0000;
    localparam logic [13:0] OP_RETURN = 14'h0008;
    localparam logic [13:0] OP_RETURN_INT = 14'h0009;
    localparam logic [13:0] OP_CALL_ACC = 14'h000A;
    localparam logic [13:0] OP_JUMP_ACC = 14'h000B;
    localparam logic BIT_WRITE_FORM = 1'h0;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // enumerations
    typedef enum logic [10:0] {
        FMT_NONE = 11'h000,
        FMT_BYTE = 11'h001,
        FMT_BIT = 11'h002,
        FMT_LIT8 = 11'h004,
        FMT_JUMP11 = 11'h008,
        FMT_PAGE7 = 11'h010,
        FMT_BANK5 = 11'h020,
        FMT_OFFSET9 = 11'h040,
        FMT_PTR_LIT6 = 11'h080,
        FMT_PTR_STEP = 11'h100,
        FMT_OP_ONLY = 11'h200,
        FMT_ILLEGAL = 11'h400
    } ifd_format_type;

    typedef enum logic [1:0] {
        STEP_PRE_INC = 2'h0,
        STEP_PRE_DEC = 2'h1,
        STEP_POST_INC = 2'h2,
        STEP_POST_DEC = 2'h3
    } ifd_step_type;

endpackage

/* src/ifd_onehot_decode.sv */
// ifd_onehot_decode: binary index to one-hot select
// assumes a same-clock binary index; purely combinational
`timescale 1ns/10ps
module ifd_onehot_decode #(
    parameter int IDX_W = 3,
    parameter int OUT_W = 8
)(
    input wire logic [IDX_W-1:0] index,
    output logic [OUT_W-1:0] select
);
    import ifd_pkg::*;

    generate
        if (OUT_W > (1 << IDX_W) || OUT_W < 2)
        begin : g_check
            $error("ifd_onehot_decode: output width does not fit index width");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // one output bit per position, exactly one set when index is below OUT_W, none set otherwise
    genvar gi;
    generate
        for (gi = 0; gi < OUT_W; gi++)
        begin : g_sel
            assign select[gi] = (index == IDX_W'(gi));
        end
    endgenerate

endmodule // ifd_onehot_decode

/* src/ifd_step_decode.sv */
// ifd_step_decode: pointer step style to increment/decrement and pre/post flags
// assumes a same-clock 2-bit style field; purely combinational
`timescale 1ns/10ps
module ifd_step_decode (
    input wire logic [1:0] pointer_step_style,
    output ifd_pkg::ifd_step_type step,
    output logic step_pre,
    output logic step_down
);
    import ifd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // four step styles
    always_comb
    begin
        step = ifd_step_type'(pointer_step_style);
        step_pre = 1'b0;
        step_down = 1'b0;
        unique case (step)
            STEP_PRE_INC:
            begin
                step_pre = 1'b1;
            end
            STEP_PRE_DEC:
            begin
                step_pre = 1'b1;
                step_down = 1'b1;
            end
            STEP_POST_INC:
            begin
                step_pre = 1'b0;
            end
            STEP_POST_DEC:
            begin
                step_down = 1'b1;
            end
        endcase
    end

endmodule // ifd_step_decode

/* src/ifd_instruction_field_decode.sv */
// ifd_instruction_field_decode: registered operand field decoder for 14-bit instruction words
// assumes instr_word and instr_valid come from the fetch stage on the same clock
// Operation
// - register location is 7 bits, addresses 0x00 to 0x7F in current bank
// - destination bit 0 sends result to accumulator, 1 back to register
// - bit instructions: opcode 13..10, bit index 9..7, register 6..0
// - bit index selects exactly one bit of the 8-bit register
// - general literal: opcode 13..8, 8-bit constant 7..0
// - call and jump: opcode 13..11, 11-bit target 10..0
// - page latch load: opcode 13..7, 7-bit literal 6..0
// - bank select load: opcode 13..5, 5-bit literal 4..0
// - offset jump: opcode 13..9, 9-bit offset 8..0
// - pointer literal: opcode 13..7, pointer select bit 6, 6-bit literal
// - pointer select picks pointer 0 or 1 and its indirect port
// - pointer step: opcode 13..3, pointer select bit 2, style 1..0
// - step style picks pre/post increment or decrement
// - don't-care bit positions are never compared; fill them with 0
// - each instruction is one 14-bit word with opcode and operands
// - register operand is read before modify and store, even write-only
`timescale 1ns/10ps
module ifd_instruction_field_decode #(
    parameter int WORD_W = 14,
    parameter int PTR_COUNT = 2
)(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [WORD_W-1:0] instr_word,
    output logic decode_valid_q,
    output ifd_pkg::ifd_format_type format_q,
    output logic illegal_q,
    output logic [ifd_pkg::REG_LOC_W-1:0] reg_loc_q,
    output logic result_to_acc_q,
    output logic result_to_reg_q,
    output logic reg_read_q,
    output logic reg_write_q,
    output logic [ifd_pkg::BIT_IDX_W-1:0] bit_index_q,
    output logic [ifd_pkg::DATA_W-1:0] bit_mask_q,
    output logic [7:0] lit8_q,
    output logic [10:0] lit11_q,
    output logic [6:0] lit7_q,
    output logic [4:0] lit5_q,
    output logic [8:0] lit9_q,
    output logic [5:0] lit6_q,
    output logic pointer_register_q,
    output logic [PTR_COUNT-1:0] indirect_port_q,
    output ifd_pkg::ifd_step_type pointer_step_style_q,
    output logic step_pre_q,
    output logic step_down_q
);
    import ifd_pkg::*;

    generate
        if (WORD_W != ifd_pkg::WORD_W)
        begin : g_word_check
            $error("ifd_instruction_field_decode: instruction word must be 14 bits");
        end
        if (PTR_COUNT != ifd_pkg::PTR_COUNT)
        begin : g_ptr_check
            $error("ifd_instruction_field_decode: exactly two pointer registers supported");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // word slices
    logic [13:0] word;
    logic [1:0] group;
    logic [3:0] sub;
    ifd_format_type format_d;
    logic dest_d;
    logic ptr_sel_d;
    logic [BIT_IDX_W-1:0] bit_index_d;
    logic [DATA_W-1:0] bit_mask_d;
    logic [PTR_COUNT-1:0] port_d;
    ifd_step_type step_d;
    logic step_pre_d;
    logic step_down_d;
    logic reg_read_d;
    logic reg_write_d;
    logic to_acc_d;
    logic to_reg_d;

    assign word = instr_word;
    assign group = word[GROUP_LSB +: 2];
    assign sub = word[SUB_LSB +: 4];
    assign dest_d = word[DEST_BIT];
    assign bit_index_d = word[BIT_IDX_LSB +: BIT_IDX_W];

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // instruction format classification, only opcode positions are compared
    always_comb
    begin
        format_d = FMT_ILLEGAL;
        if (group == GROUP_BIT)
        begin
            format_d = FMT_BIT;
        end
        else if (group == GROUP_JUMP)
        begin
            format_d = FMT_JUMP11;
        end
        else if (group == GROUP_HIGH)
        begin
            if (word[13:9] == OFFSET_JUMP_OP)
            begin
                format_d = FMT_OFFSET9;
            end
            else if (word[13:7] == PAGE_LOAD_OP)
            begin
                format_d = FMT_PAGE7;
            end
            else if (word[13:7] == PTR_ADD_OP || word[13:7] == PTR_READ_LIT_OP || word[13:7] == PTR_WRITE_LIT_OP)
            begin
                format_d = FMT_PTR_LIT6;
            end
            else if (HIGH_BYTE_SET[sub])
            begin
                format_d = FMT_BYTE;
            end
            else if (HIGH_LIT8_SET[sub])
            begin
                format_d = FMT_LIT8;
            end
        end
        else
        begin
            if (sub != SUB_NONE || word[DEST_BIT])
            begin
                format_d = FMT_BYTE;
            end
            else if (word[13:5] == BANK_LOAD_OP)
            begin
                format_d = FMT_BANK5;
            end
            else if (word[13:3] == PTR_READ_STEP_OP || word[13:3] == PTR_WRITE_STEP_OP)
            begin
                format_d = FMT_PTR_STEP;
            end
            else if (word == OP_IDLE || word == OP_RETURN || word == OP_RETURN_INT || word == OP_CALL_ACC
                     || word == OP_JUMP_ACC)
            begin
                format_d = FMT_OP_ONLY;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // pointer select from the bit its format uses
    always_comb
    begin
        if (format_d == FMT_PTR_STEP)
        begin
            ptr_sel_d = word[PTR_STEP_SEL_BIT];
        end
        else
        begin
            ptr_sel_d = word[PTR_LIT_SEL_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // register access and result routing
    always_comb
    begin
        reg_read_d = 1'b0;
        reg_write_d = 1'b0;
        to_acc_d = 1'b0;
        to_reg_d = 1'b0;
        unique case (format_d)
            FMT_BYTE:
            begin
                reg_read_d = 1'b1;
                reg_write_d = dest_d;
                to_acc_d = ~dest_d;
                to_reg_d = dest_d;
            end
            FMT_BIT:
            begin
                reg_read_d = 1'b1;
                reg_write_d = (word[BIT_TEST_BIT] == BIT_WRITE_FORM);
                to_reg_d = (word[BIT_TEST_BIT] == BIT_WRITE_FORM);
            end
            FMT_NONE, FMT_LIT8, FMT_JUMP11, FMT_PAGE7, FMT_BANK5, FMT_OFFSET9, FMT_PTR_LIT6, FMT_PTR_STEP,
            FMT_OP_ONLY, FMT_ILLEGAL:
            begin
                reg_read_d = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // helper decoders
    ifd_onehot_decode #(
        .IDX_W(BIT_IDX_W),
        .OUT_W(DATA_W)
    ) u_bit_mask (
        .index(bit_index_d),
        .select(bit_mask_d)
    );

    ifd_onehot_decode #(
        .IDX_W(1),
        .OUT_W(PTR_COUNT)
    ) u_port_sel (
        .index(ptr_sel_d),
        .select(port_d)
    );

    ifd_step_decode u_step (
        .pointer_step_style(word[STEP_LSB +: 2]),
        .step(step_d),
        .step_pre(step_pre_d),
        .step_down(step_down_d)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // valid pulse and format
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            decode_valid_q <= 1'b0;
            format_q <= FMT_NONE;
            illegal_q <= 1'b0;
        end
        else
        begin
            decode_valid_q <= instr_valid;
            if (instr_valid)
            begin
                format_q <= format_d;
                illegal_q <= (format_d == FMT_ILLEGAL);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // register operand and routing
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_loc_q <= '0;
            result_to_acc_q <= 1'b0;
            result_to_reg_q <= 1'b0;
            reg_read_q <= 1'b0;
            reg_write_q <= 1'b0;
        end
        else if (instr_valid)
        begin
            reg_loc_q <= word[REG_LOC_LSB +: REG_LOC_W];
            result_to_acc_q <= to_acc_d;
            result_to_reg_q <= to_reg_d;
            reg_read_q <= reg_read_d;
            reg_write_q <= reg_write_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // bit operand
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bit_index_q <= '0;
            bit_mask_q <= '0;
        end
        else if (instr_valid)
        begin
            bit_index_q <= bit_index_d;
            bit_mask_q <= bit_mask_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // literal fields
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lit8_q <= '0;
            lit11_q <= '0;
            lit7_q <= '0;
            lit5_q <= '0;
            lit9_q <= '0;
            lit6_q <= '0;
        end
        else if (instr_valid)
        begin
            lit8_q <= word[LIT8_LSB +: 8];
            lit11_q <= word[LIT11_LSB +: 11];
            lit7_q <= word[LIT7_LSB +: 7];
            lit5_q <= word[LIT5_LSB +: 5];
            lit9_q <= word[LIT9_LSB +: 9];
            lit6_q <= word[LIT6_LSB +: 6];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // pointer select and step style
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pointer_register_q <= 1'b0;
            indirect_port_q <= '0;
            pointer_step_style_q <= STEP_PRE_INC;
            step_pre_q <= 1'b0;
            step_down_q <= 1'b0;
        end
        else if (instr_valid)
        begin
            pointer_register_q <= ptr_sel_d;
            indirect_port_q <= port_d;
            pointer_step_style_q <= step_d;
            step_pre_q <= step_pre_d;
            step_down_q <= step_down_d;
        end
    end

endmodule // ifd_instruction_field_decode

/* test/ifd_instruction_field_decode_props.sv */
// ifd_instruction_field_decode_props: port-level checks of the field decoder
// assumes one clock domain with an asynchronous active-low reset
`timescale 1ns/10ps
module ifd_props
    import ifd_pkg::*;
#(
    parameter int WORD_W = 14,
    parameter int PTR_COUNT = 2
)(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [WORD_W-1:0] instr_word,
    input wire logic decode_valid_q,
    input ifd_pkg::ifd_format_type format_q,
    input wire logic illegal_q,
    input wire logic [6:0] reg_loc_q,
    input wire logic result_to_acc_q,
    input wire logic result_to_reg_q,
    input wire logic reg_read_q,
    input wire logic [2:0] bit_index_q,
    input wire logic [7:0] bit_mask_q,
    input wire logic [7:0] lit8_q,
    input wire logic [10:0] lit11_q,
    input wire logic pointer_register_q,
    input wire logic [PTR_COUNT-1:0] indirect_port_q,
    input ifd_pkg::ifd_step_type pointer_step_style_q,
    input wire logic step_pre_q,
    input wire logic step_down_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_valid; 1 |=> decode_valid_q == $past(instr_valid); endproperty
    a_valid: assert property (p_valid) else $error("decode valid not one cycle after word");
    property p_reg; instr_valid |=> reg_loc_q == $past(instr_word[6:0]); endproperty
    a_reg: assert property (p_reg) else $error("register location wrong");
    property p_bit;
        instr_valid |=> bit_index_q == $past(instr_word[9:7]) && bit_mask_q == (8'h01 << bit_index_q);
    endproperty
    a_bit: assert property (p_bit) else $error("bit index or mask wrong");
    property p_lit; instr_valid |=> lit8_q == $past(instr_word[7:0]) && lit11_q == $past(instr_word[10:0]); endproperty
    a_lit: assert property (p_lit) else $error("literal field wrong");
    property p_dest;
        decode_valid_q && format_q == FMT_BYTE |-> result_to_reg_q == lit8_q[7] && result_to_acc_q == !lit8_q[7] && reg_read_q;
    endproperty
    a_dest: assert property (p_dest) else $error("destination select wrong");
    property p_ptr;
        instr_valid |=> pointer_register_q == (format_q == FMT_PTR_STEP ? $past(instr_word[2]) : $past(instr_word[6]))
            && indirect_port_q == (pointer_register_q ? 2'h2 : 2'h1);
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer select wrong");
    property p_step;
        decode_valid_q |-> step_pre_q == (pointer_step_style_q inside {STEP_PRE_INC, STEP_PRE_DEC})
            && step_down_q == (pointer_step_style_q inside {STEP_PRE_DEC, STEP_POST_DEC});
    endproperty
    a_step: assert property (p_step) else $error("step style flags wrong");
    property p_fmt; decode_valid_q |-> $onehot(format_q) && illegal_q == (format_q == FMT_ILLEGAL); endproperty
    a_fmt: assert property (p_fmt) else $error("format not one-hot or illegal flag wrong");
    property p_hold; !instr_valid |=> $stable(reg_loc_q) && $stable(format_q); endproperty
    a_hold: assert property (p_hold) else $error("fields changed without a word");
    c_byte: cover property (decode_valid_q && format_q == FMT_BYTE);
    c_step: cover property (decode_valid_q && format_q == FMT_PTR_STEP);
    c_bad: cover property (decode_valid_q && illegal_q);
endmodule // ifd_props
bind ifd_instruction_field_decode ifd_props #(.WORD_W(WORD_W), .PTR_COUNT(PTR_COUNT)) u_props (.clock, .rst_n,
    .instr_valid, .instr_word, .decode_valid_q, .format_q, .illegal_q, .reg_loc_q, .result_to_acc_q,
    .result_to_reg_q, .reg_read_q, .bit_index_q, .bit_mask_q, .lit8_q, .lit11_q, .pointer_register_q,
    .indirect_port_q, .pointer_step_style_q, .step_pre_q, .step_down_q);

/* test/ifd_fetch_model.sv */
// ifd_fetch_model: fetch stage presenting queued words with random stalls
// assumes the bench pushes words; drives just after each rising edge
`timescale 1ns/10ps
module ifd_fetch_model (
    input wire logic clock,
    input wire logic rst_n,
    output logic instr_valid,
    output logic [13:0] instr_word
);
    logic [13:0] words[$];
    int seed = 32'he872c43c;
    initial instr_valid = 1'b0;
    initial instr_word = 14'h0000;
    task push(input logic [13:0] w);
        words.push_back(w);
    endtask
    always @(posedge clock)
    begin
        #1;
        if (rst_n === 1'b1 && words.size() != 0 && ($random(seed) & 3) != 0)
        begin
            instr_valid = 1'b1;
            instr_word = words.pop_front();
        end
        else
        begin
            instr_valid = 1'b0;
            instr_word = ~instr_word;
        end
    end
endmodule // ifd_fetch_model

/* test/ifd_instruction_field_decode_bench.sv */
// ifd_instruction_field_decode_bench: reference-model bench for the field decoder
// assumes ifd_pkg and the fetch model are compiled first
`timescale 1ns/10ps
module ifd_instruction_field_decode_bench;
    import ifd_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid, decode_valid_q, illegal_q, pointer_register_q, step_pre_q, step_down_q;
    logic result_to_acc_q, result_to_reg_q, reg_read_q, reg_write_q, v;
    logic [13:0] instr_word, w;
    logic [6:0] reg_loc_q, lit7_q;
    logic [2:0] bit_index_q;
    logic [7:0] bit_mask_q, lit8_q;
    logic [10:0] lit11_q;
    logic [4:0] lit5_q;
    logic [8:0] lit9_q;
    logic [5:0] lit6_q;
    logic [1:0] indirect_port_q;
    ifd_format_type format_q;
    ifd_step_type pointer_step_style_q;
    logic [13:0] pend[$];
    int fail_count = 0;
    int tests_run = 0;
    int seed = 32'he872c43c;
    logic [13:0] table_w[20] = '{14'h0F85, 14'h0080, 14'h0000, 14'h0008, 14'h0009, 14'h000A, 14'h000B,
        14'h0001, 14'h003F, 14'h0010, 14'h0011, 14'h0016, 14'h001F, 14'h0100, 14'h0103, 14'h1F80,
        14'h3180, 14'h3100, 14'h3FFF, 14'h3400};
    always #5 clock = ~clock;
    ifd_fetch_model fetch (.clock(clock), .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word));
    ifd_instruction_field_decode DUT (.clock(clock), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .decode_valid_q(decode_valid_q), .format_q(format_q), .illegal_q(illegal_q),
        .reg_loc_q(reg_loc_q), .result_to_acc_q(result_to_acc_q), .result_to_reg_q(result_to_reg_q),
        .reg_read_q(reg_read_q), .reg_write_q(reg_write_q), .bit_index_q(bit_index_q), .bit_mask_q(bit_mask_q),
        .lit8_q(lit8_q), .lit11_q(lit11_q), .lit7_q(lit7_q), .lit5_q(lit5_q), .lit9_q(lit9_q), .lit6_q(lit6_q),
        .pointer_register_q(pointer_register_q), .indirect_port_q(indirect_port_q),
        .pointer_step_style_q(pointer_step_style_q), .step_pre_q(step_pre_q), .step_down_q(step_down_q));
    ////////////////////////////////////////////////////////////////////////
    function automatic ifd_format_type ref_fmt(input logic [13:0] x);
        if (x[13:12] == 2'h1) return FMT_BIT;
        if (x[13:12] == 2'h2) return FMT_JUMP11;
        if (x[13:12] == 2'h3)
        begin
            if (x[13:9] == 5'h19) return FMT_OFFSET9;
            if (x[13:7] == 7'h63) return FMT_PAGE7;
            if (x[13:7] inside {7'h62, 7'h7E, 7'h7F}) return FMT_PTR_LIT6;
            if (x[11:8] inside {4'h5, 4'h6, 4'h7, 4'hB, 4'hD}) return FMT_BYTE;
            return FMT_LIT8;
        end
        if (x[11:8] != 4'h0 || x[7]) return FMT_BYTE;
        if (x[13:5] == 9'h001) return FMT_BANK5;
        if (x[13:4] == 10'h001) return FMT_PTR_STEP;
        if (x inside {14'h0000, 14'h0008, 14'h0009, 14'h000A, 14'h000B}) return FMT_OP_ONLY;
        return FMT_ILLEGAL;
    endfunction
    task chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk_fmt(input ifd_format_type got, input ifd_format_type exp);
        chk(64'(got), 64'(exp));
    endtask
    task check_word(input logic [13:0] x);
        ifd_format_type f;
        logic by, bi, p;
        f = ref_fmt(x);
        by = (f == FMT_BYTE);
        bi = (f == FMT_BIT);
        p = (f == FMT_PTR_STEP) ? x[2] : x[6];
        chk_fmt(format_q, f);
        chk(illegal_q, f == FMT_ILLEGAL);
        chk(reg_loc_q, x[6:0]);
        chk({result_to_acc_q, result_to_reg_q, reg_read_q, reg_write_q},
            {by & ~x[7], (by & x[7]) | (bi & ~x[11]), by | bi, (by & x[7]) | (bi & ~x[11])});
        chk({bit_index_q, bit_mask_q}, {x[9:7], 8'h01 << x[9:7]});
        chk({lit8_q, lit11_q, lit7_q, lit5_q, lit9_q, lit6_q},
            {x[7:0], x[10:0], x[6:0], x[4:0], x[8:0], x[5:0]});
        chk({pointer_register_q, indirect_port_q}, {p, p ? 2'h2 : 2'h1});
        chk({pointer_step_style_q, step_pre_q, step_down_q}, {x[1:0], ~x[1], x[0]});
    endtask
    always @(posedge clock)
    begin
        v = instr_valid;
        w = instr_word;
        #2;
        if (rst_n !== 1'b1)
            pend.delete();
        else
        begin
            if (v === 1'b1) pend.push_back(w);
            chk(decode_valid_q, pend.size() != 0);
            if (pend.size() != 0) check_word(pend.pop_front());
        end
    end
    task stop_test;
        $display("checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task drain;
        for (int i = 0; i < 4000 && (fetch.words.size() != 0 || pend.size() != 0); i++) @(posedge clock);
        repeat (3) @(posedge clock);
    endtask
    initial
    begin
        #100000;
        fail_count++;
        stop_test();
    end
    initial
    begin
        repeat (12) @(posedge clock);
        #1 rst_n = 1'b1;
        foreach (table_w[i]) fetch.push(table_w[i]);
        for (int i = 0; i < 400; i++) fetch.push(14'($random(seed)));
        drain();
        #1 rst_n = 1'b0;
        #1 chk({decode_valid_q, format_q, reg_loc_q}, 0);
        @(posedge clock);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 40; i++) fetch.push(14'($random(seed)));
        drain();
        stop_test();
    end
endmodule // ifd_instruction_field_decode_bench
